// ---- hdl/tic_top.sv ----
// Timer input capture unit with 16-bit counter and APB register slave
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Two mode bits choose capture, reload or compare
// - Counter is two separately accessed byte registers
// - Three channels, own edge detectors, one counter
// - Filter rejects pulses under four clocks
// - Filter enables at bits 6..4, third register
// - Edge code 00 fall, 01 rise, 10 both
// - Edge fields 5:4, 3:2, 1:0 of second register
// - Channel enables at bits 6..4, first register
// - Selected edge copies counter to channel result
// - Edge sets channel flag; only software clears
// - Interrupt when flag, capture and global enables
// - Clear-on-capture zeroes counter after the latch
// - Each result is separate low, high bytes
// - Reset clears counter, results and control registers
// - Run bit low halts and keeps count
// - Prescale codes divide by 4 up to 512
// - Overflow sets sticky flag; software clears it
// - Without clear-on-capture, counting continues unchanged
module tic_top (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // APB slave
  input  wire tic_pkg::tic_apb_req_t apb_req,
  output tic_pkg::tic_apb_rsp_t      apb_rsp,
  // Capture pins
  input  wire logic                  capture_pin0,
  input  wire logic                  capture_pin1,
  input  wire logic                  capture_pin2,
  // Interrupt request
  output logic                       capture_irq
);

  typedef struct packed {
    logic [2:0]            capen;
    logic [2:0]            flag;
    logic [5:0]            esel;
    logic [2:0]            filt;
    logic                  ovf;
    logic                  run;
    logic                  cmp;
    logic [7:0]            mode;
    logic [1:0]            ien;
    logic [15:0]           cnt;
    logic [8:0]            psc;
    logic [2:0][15:0]      res;
    logic                  irq;
    tic_pkg::tic_apb_rsp_t rsp;
  } tic_state_t;

  tic_state_t          st_r;
  tic_state_t          st_nxt;
  logic [2:0]          edge_evt;
  logic [2:0]          hit;
  logic [2:0]          pins;
  logic                tick;
  logic                wr;
  logic                setup;
  logic [9:0]          idx;
  logic [7:0]          wdat;
  tic_pkg::tic_mode_t  tmode;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [8:0] psc_last(input logic [2:0] code);
    logic [9:0] d;
    d = tic_pkg::PSC_BASE << code;
    return 9'(d - 10'h001);
  endfunction

  function automatic tic_pkg::tic_mode_t mode_of(input logic cmp, input logic rld);
    if (cmp) begin
      return tic_pkg::MODE_COMPARE;
    end else if (rld) begin
      return tic_pkg::MODE_RELOAD;
    end
    return tic_pkg::MODE_CAPTURE;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Channels share one counter, each with its own edge logic
  assign pins = {capture_pin2, capture_pin1, capture_pin0};

  for (genvar i = 0; i < 3; i++) begin : g_ch
    tic_chan #(
      .FILT_LEN (tic_pkg::FILT_CYCLES)
    ) u_chan (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .pin        (pins[i]),
      .filt_on    (st_r.filt[i]),
      .edge_sel   (st_r.esel[2*i +: 2]),
      .edge_pulse (edge_evt[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  assign tmode = mode_of(st_r.cmp, st_r.mode[tic_pkg::RLD_BIT]);
  // Reload and compare are not built; only capture mode latches
  assign hit   = (tmode == tic_pkg::MODE_CAPTURE) ? (st_r.capen & edge_evt) : 3'h0;
  assign tick  = st_r.run && (st_r.psc == psc_last(st_r.mode[tic_pkg::PSC_LSB +: 3]));
  assign setup = apb_req.psel && !apb_req.penable;
  assign wr    = apb_req.psel && apb_req.penable && apb_req.pwrite && st_r.rsp.pready && !st_r.rsp.pslverr;
  assign idx   = apb_req.paddr[11:2];
  assign wdat  = apb_req.pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;

    // Prescaler and counter
    if (st_r.run) begin
      st_nxt.psc = tick ? 9'h000 : st_r.psc + 9'h001;
    end
    if (tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end

    // Capture takes the count before this cycle's update
    for (int i = 0; i < 3; i++) begin
      if (hit[i]) begin
        st_nxt.res[i] = st_r.cnt;
      end
    end
    if (|hit && st_r.mode[tic_pkg::CLR_BIT]) begin
      st_nxt.cnt = tic_pkg::RST_CNT;
    end

    // Software writes; a counter write beats the hardware update
    if (wr) begin
      unique case (idx)
        tic_pkg::IDX_CAPEN: begin
          st_nxt.capen = wdat[tic_pkg::CAPEN_LSB +: 3];
          st_nxt.flag  = wdat[2:0];
        end
        tic_pkg::IDX_EDGE:    st_nxt.esel = wdat[5:0];
        tic_pkg::IDX_FILT:    st_nxt.filt = wdat[tic_pkg::FILT_LSB +: 3];
        tic_pkg::IDX_CTRL: begin
          st_nxt.ovf = wdat[tic_pkg::OVF_BIT];
          st_nxt.run = wdat[tic_pkg::RUN_BIT];
          st_nxt.cmp = wdat[tic_pkg::CMP_BIT];
        end
        tic_pkg::IDX_MODE:    st_nxt.mode = wdat;
        tic_pkg::IDX_CNTL:    st_nxt.cnt[7:0] = wdat;
        tic_pkg::IDX_CNTH:    st_nxt.cnt[15:8] = wdat;
        tic_pkg::IDX_RES0_LO: st_nxt.res[0][7:0] = wdat;
        tic_pkg::IDX_RES0_HI: st_nxt.res[0][15:8] = wdat;
        tic_pkg::IDX_RES1_LO: st_nxt.res[1][7:0] = wdat;
        tic_pkg::IDX_RES1_HI: st_nxt.res[1][15:8] = wdat;
        tic_pkg::IDX_RES2_LO: st_nxt.res[2][7:0] = wdat;
        tic_pkg::IDX_RES2_HI: st_nxt.res[2][15:8] = wdat;
        tic_pkg::IDX_IEN:     st_nxt.ien = wdat[1:0];
        default: ;
      endcase
    end

    // Hardware sets win over a software clear in the same cycle
    st_nxt.flag = st_nxt.flag | hit;
    if (tick && st_r.cnt == tic_pkg::CNT_TOP) begin
      st_nxt.ovf = 1'b1;
    end

    st_nxt.irq = (|st_r.flag) && st_r.ien[tic_pkg::IEN_CAP] && st_r.ien[tic_pkg::IEN_GLB];

    // Read data is prepared in the setup cycle so the access ends at once
    st_nxt.rsp.pready  = setup;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata  = 32'h0000_0000;
    if (setup) begin
      unique case (idx)
        tic_pkg::IDX_CAPEN:   st_nxt.rsp.prdata[7:0] = {1'b0, st_r.capen, 1'b0, st_r.flag};
        tic_pkg::IDX_EDGE:    st_nxt.rsp.prdata[7:0] = {2'h0, st_r.esel};
        tic_pkg::IDX_FILT:    st_nxt.rsp.prdata[7:0] = {1'b0, st_r.filt, 4'h0};
        tic_pkg::IDX_CTRL:    st_nxt.rsp.prdata[7:0] = {st_r.ovf, 4'h0, st_r.run, 1'b0, st_r.cmp};
        tic_pkg::IDX_MODE:    st_nxt.rsp.prdata[7:0] = st_r.mode;
        tic_pkg::IDX_CNTL:    st_nxt.rsp.prdata[7:0] = st_r.cnt[7:0];
        tic_pkg::IDX_CNTH:    st_nxt.rsp.prdata[7:0] = st_r.cnt[15:8];
        tic_pkg::IDX_RES0_LO: st_nxt.rsp.prdata[7:0] = st_r.res[0][7:0];
        tic_pkg::IDX_RES0_HI: st_nxt.rsp.prdata[7:0] = st_r.res[0][15:8];
        tic_pkg::IDX_RES1_LO: st_nxt.rsp.prdata[7:0] = st_r.res[1][7:0];
        tic_pkg::IDX_RES1_HI: st_nxt.rsp.prdata[7:0] = st_r.res[1][15:8];
        tic_pkg::IDX_RES2_LO: st_nxt.rsp.prdata[7:0] = st_r.res[2][7:0];
        tic_pkg::IDX_RES2_HI: st_nxt.rsp.prdata[7:0] = st_r.res[2][15:8];
        tic_pkg::IDX_IEN:     st_nxt.rsp.prdata[7:0] = {6'h00, st_r.ien};
        default:              st_nxt.rsp.pslverr = 1'b1;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp     = st_r.rsp;
  assign capture_irq = st_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_cap0;
    hit[0] && !wr;
  endsequence

  property p_latch;
    @(posedge clk_sys) disable iff (rst)
      s_cap0 |=> (st_r.res[0] == $past(st_r.cnt));
  endproperty
  a_latch: assert property (p_latch) else $error("Result missed counter value");

  property p_flag;
    @(posedge clk_sys) disable iff (rst)
      (|hit) |=> ((st_r.flag & $past(hit)) == $past(hit));
  endproperty
  a_flag: assert property (p_flag) else $error("Capture flag not set");

  property p_clear;
    @(posedge clk_sys) disable iff (rst)
      (|hit && st_r.mode[tic_pkg::CLR_BIT] && !wr) |=> (st_r.cnt == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("Counter not cleared on capture");

  property p_keep;
    @(posedge clk_sys) disable iff (rst)
      (|hit && !st_r.mode[tic_pkg::CLR_BIT] && !wr && !tick) |=> $stable(st_r.cnt);
  endproperty
  a_keep: assert property (p_keep) else $error("Counter disturbed by capture");

  property p_halt;
    @(posedge clk_sys) disable iff (rst)
      (!st_r.run && !wr && !(|hit)) [*2] |-> $stable(st_r.cnt);
  endproperty
  a_halt: assert property (p_halt) else $error("Halted counter moved");

  sequence s_wrap;
    tick && st_r.cnt == 16'hffff && !(|hit) && !wr;
  endsequence

  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
      s_wrap |=> (st_r.cnt == 16'h0000 && st_r.ovf);
  endproperty
  a_wrap: assert property (p_wrap) else $error("Wrap or overflow flag wrong");

  property p_ovf;
    @(posedge clk_sys) disable iff (rst)
      (st_r.ovf && !wr) |=> st_r.ovf;
  endproperty
  a_ovf: assert property (p_ovf) else $error("Overflow flag lost");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      ((|st_r.flag) && st_r.ien == 2'h3) |=> capture_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised");

  property p_mode;
    @(posedge clk_sys) disable iff (rst)
      (st_r.cmp || st_r.mode[tic_pkg::RLD_BIT]) |=> ($past(st_r.flag) == 3'h0) |-> (st_r.flag == 3'h0 || $past(wr));
  endproperty
  a_mode: assert property (p_mode) else $error("Capture outside capture mode");

endmodule // tic_top
`default_nettype wire

// ---- include/tic_pkg.sv ----
// Shared constants, types and register map of the timer input capture unit
`default_nettype none
package tic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CAPEN   = 10'h092;
  localparam logic [9:0] IDX_EDGE    = 10'h093;
  localparam logic [9:0] IDX_FILT    = 10'h094;
  localparam logic [9:0] IDX_CTRL    = 10'h0c8;
  localparam logic [9:0] IDX_MODE    = 10'h0c9;
  localparam logic [9:0] IDX_CNTL    = 10'h0cc;
  localparam logic [9:0] IDX_CNTH    = 10'h0cd;
  localparam logic [9:0] IDX_RES0_LO = 10'h0e4;
  localparam logic [9:0] IDX_RES0_HI = 10'h0e5;
  localparam logic [9:0] IDX_RES1_LO = 10'h0e6;
  localparam logic [9:0] IDX_RES1_HI = 10'h0e7;
  localparam logic [9:0] IDX_RES2_LO = 10'h0ed;
  localparam logic [9:0] IDX_RES2_HI = 10'h0ee;
  localparam logic [9:0] IDX_IEN     = 10'h0f0;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CAPEN_LSB = 4;
  localparam int FILT_LSB  = 4;
  localparam int OVF_BIT   = 7;
  localparam int RUN_BIT   = 2;
  localparam int CMP_BIT   = 0;
  localparam int RLD_BIT   = 7;
  localparam int PSC_LSB   = 4;
  localparam int CLR_BIT   = 3;
  localparam int IEN_CAP   = 0;
  localparam int IEN_GLB   = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counts
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_CNT     = 16'h0000;
  localparam logic [15:0] CNT_TOP     = 16'hffff;
  localparam int          FILT_CYCLES = 4;
  localparam logic [9:0]  PSC_BASE    = 10'h004;

  ////////////////////////////////////////////////////////////////////////////
  // Edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  typedef enum logic [1:0] {MODE_CAPTURE, MODE_RELOAD, MODE_COMPARE} tic_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tic_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tic_apb_rsp_t;

endpackage
`default_nettype wire

// ---- hdl/tic_chan.sv ----
// One capture channel: synchroniser, glitch filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module tic_chan #(
  parameter int FILT_LEN = tic_pkg::FILT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Pin and settings
  input  wire logic       pin,
  input  wire logic       filt_on,
  input  wire logic [1:0] edge_sel,
  // Event
  output logic            edge_pulse
);

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       filt;
    logic       prev;
    logic [2:0] cnt;
    logic       evt;
  } tic_chan_st_t;

  tic_chan_st_t st_r;
  tic_chan_st_t st_nxt;

  if (FILT_LEN < 2 || FILT_LEN > 8) begin : g_chk
    $error("FILT_LEN out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin;
    st_nxt.s2 = st_r.s1;
    if (!filt_on) begin
      st_nxt.filt = st_r.s2;
      st_nxt.cnt  = 3'h0;
    end else if (st_r.s2 != st_r.filt) begin
      // Level must disagree for FILT_LEN cycles in a row before it is taken
      if (st_r.cnt == 3'(FILT_LEN - 1)) begin
        st_nxt.filt = st_r.s2;
        st_nxt.cnt  = 3'h0;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end else begin
      st_nxt.cnt = 3'h0;
    end
    st_nxt.prev = st_r.filt;
    unique case (edge_sel)
      tic_pkg::EDGE_FALL: st_nxt.evt = st_r.prev & ~st_r.filt;
      tic_pkg::EDGE_RISE: st_nxt.evt = ~st_r.prev & st_r.filt;
      tic_pkg::EDGE_BOTH: st_nxt.evt = st_r.prev ^ st_r.filt;
      default:            st_nxt.evt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_pulse = st_r.evt;

  //////////////////////////////////////////////////////////////////////////////
  property p_filt;
    @(posedge clk_sys) disable iff (rst)
      (filt_on && $past(filt_on, 4) && st_r.filt != $past(st_r.filt))
      |-> ($past(st_r.s2, 1) == st_r.filt && $past(st_r.s2, 4) == st_r.filt);
  endproperty
  a_filt: assert property (p_filt) else $error("Filter passed a short pulse");

endmodule // tic_chan
`default_nettype wire

// ---- dv/tic_pulse_src.sv ----
// Model of the external pulse sources on the three capture pins
`timescale 1ns/1ps
`default_nettype none
module tic_pulse_src (
  // Clock
  input  wire logic clk_sys,
  // Capture pins
  output logic      capture_pin0,
  output logic      capture_pin1,
  output logic      capture_pin2
);
  logic [2:0] lvl_r;

  assign capture_pin0 = lvl_r[0];
  assign capture_pin1 = lvl_r[1];
  assign capture_pin2 = lvl_r[2];

  initial lvl_r = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Levels change just after an edge, like a clean push-pull source
  task automatic set_pin(input int ch, input logic v);
    @(posedge clk_sys);
    lvl_r[ch] <= v;
  endtask

  // Width in clocks; a short width sends a glitch on purpose
  task automatic pulse(input int ch, input int width);
    set_pin(ch, ~lvl_r[ch]);
    repeat (width - 1) @(posedge clk_sys);
    set_pin(ch, ~lvl_r[ch]);
  endtask
endmodule // tic_pulse_src
`default_nettype wire

// ---- dv/timer_input_capture_unit_bench.sv ----
// Self-checking bench for the timer input capture unit
`timescale 1ns/1ps
`default_nettype none
module timer_input_capture_unit_bench;
  logic                  clk_sys;
  logic                  rst;
  tic_pkg::tic_apb_req_t apb_req;
  tic_pkg::tic_apb_rsp_t apb_rsp;
  logic                  capture_pin0;
  logic                  capture_pin1;
  logic                  capture_pin2;
  logic                  capture_irq;
  int                    fails = 0;
  int                    checked = 0;
  int                    cycles = 0;
  logic [31:0]           rdat;
  logic                  rerr;
  logic [31:0]           keep;
  logic [9:0]            res_lo [3] = '{tic_pkg::IDX_RES0_LO, tic_pkg::IDX_RES1_LO, tic_pkg::IDX_RES2_LO};
  logic [9:0]            res_hi [3] = '{tic_pkg::IDX_RES0_HI, tic_pkg::IDX_RES1_HI, tic_pkg::IDX_RES2_HI};

  tic_top tic_top_inst (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .apb_req      (apb_req),
    .apb_rsp      (apb_rsp),
    .capture_pin0 (capture_pin0),
    .capture_pin1 (capture_pin1),
    .capture_pin2 (capture_pin2),
    .capture_irq  (capture_irq)
  );

  tic_pulse_src tic_pulse_src_inst (
    .clk_sys      (clk_sys),
    .capture_pin0 (capture_pin0),
    .capture_pin1 (capture_pin1),
    .capture_pin2 (capture_pin2)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Longest prescale sweep dominates; ceiling leaves wide margin
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {24'h0, d}};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    @(posedge clk_sys);
    while (apb_rsp.pready !== 1'b1) @(posedge clk_sys);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rc(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({31'h0, rerr}, 32'h0);
    chk(rdat, {24'h0, exp});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    rst = 1'b1;
    apb_req = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rc(tic_pkg::IDX_CAPEN, 8'h00);
    rc(tic_pkg::IDX_FILT, 8'h00);
    rc(tic_pkg::IDX_CNTL, 8'h00);
    rc(tic_pkg::IDX_CNTH, 8'h00);
    rc(tic_pkg::IDX_RES0_LO, 8'h00);
    rc(tic_pkg::IDX_RES0_HI, 8'h00);
    apb(1'b1, 10'h000, 8'hff);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 10'h000, 8'h00);
    chk({rerr, rdat[30:0]}, 32'h80000000);
    $display("test reset_and_map done");
    // Every prescale code: about 16 ticks in 16 divided periods
    for (int c = 0; c < 8; c++) begin
      wr(tic_pkg::IDX_CNTL, 8'h00);
      wr(tic_pkg::IDX_CNTH, 8'h00);
      wr(tic_pkg::IDX_MODE, 8'(c << tic_pkg::PSC_LSB));
      wr(tic_pkg::IDX_CTRL, 8'h04);
      idle(16 * (4 << c));
      wr(tic_pkg::IDX_CTRL, 8'h00);
      apb(1'b0, tic_pkg::IDX_CNTL, 8'h00);
      checked++;
      if ((rdat >= 32'd15 && rdat <= 32'd17) !== 1'b1) begin
        fails++;
        $display("[FAIL] %0t got %h exp %h", $time, rdat, 32'h10);
      end
      keep = rdat;
      idle(40);
      apb(1'b0, tic_pkg::IDX_CNTL, 8'h00);
      chk(rdat, keep);
      rc(tic_pkg::IDX_CNTH, 8'h00);
    end
    wr(tic_pkg::IDX_MODE, 8'h00);
    wr(tic_pkg::IDX_CNTL, 8'hff);
    wr(tic_pkg::IDX_CNTH, 8'hff);
    wr(tic_pkg::IDX_CTRL, 8'h04);
    // Old prescaler phase may need up to one long period
    idle(1100);
    rc(tic_pkg::IDX_CTRL, 8'h84);
    wr(tic_pkg::IDX_CTRL, 8'h00);
    rc(tic_pkg::IDX_CNTH, 8'h00);
    rc(tic_pkg::IDX_CTRL, 8'h00);
    $display("test counter done");
    // Halted counter makes the captured value exact
    wr(tic_pkg::IDX_CNTH, 8'h5a);
    for (int ch = 0; ch < 3; ch++) begin
      for (int code = 0; code < 4; code++) begin
        wr(tic_pkg::IDX_CNTL, 8'(16 * ch + code));
        wr(tic_pkg::IDX_EDGE, 8'(code << (2 * ch)));
        wr(tic_pkg::IDX_CAPEN, 8'(16 << ch));
        tic_pulse_src_inst.set_pin(ch, 1'b1);
        idle(12);
        rc(tic_pkg::IDX_CAPEN, 8'((16 << ch) | ((code == 1 || code == 2) << ch)));
        wr(tic_pkg::IDX_CAPEN, 8'(16 << ch));
        tic_pulse_src_inst.set_pin(ch, 1'b0);
        idle(12);
        rc(tic_pkg::IDX_CAPEN, 8'((16 << ch) | ((code == 0 || code == 2) << ch)));
        if (code != 3) begin
          rc(res_lo[ch], 8'(16 * ch + code));
          rc(res_hi[ch], 8'h5a);
        end
      end
    end
    wr(tic_pkg::IDX_CAPEN, 8'h00);
    wr(tic_pkg::IDX_EDGE, 8'h2a);
    for (int ch = 0; ch < 3; ch++) begin
      tic_pulse_src_inst.pulse(ch, 6);
    end
    idle(12);
    rc(tic_pkg::IDX_CAPEN, 8'h00);
    $display("test edges done");
    wr(tic_pkg::IDX_CAPEN, 8'h20);
    wr(tic_pkg::IDX_FILT, 8'h20);
    tic_pulse_src_inst.pulse(1, 3);
    idle(14);
    rc(tic_pkg::IDX_CAPEN, 8'h20);
    tic_pulse_src_inst.pulse(1, 6);
    idle(14);
    rc(tic_pkg::IDX_CAPEN, 8'h22);
    rc(tic_pkg::IDX_FILT, 8'h20);
    wr(tic_pkg::IDX_FILT, 8'h70);
    rc(tic_pkg::IDX_FILT, 8'h70);
    wr(tic_pkg::IDX_FILT, 8'h00);
    $display("test filter done");
    wr(tic_pkg::IDX_CAPEN, 8'h10);
    wr(tic_pkg::IDX_CTRL, 8'h01);
    tic_pulse_src_inst.pulse(0, 6);
    idle(12);
    rc(tic_pkg::IDX_CAPEN, 8'h10);
    wr(tic_pkg::IDX_CTRL, 8'h00);
    wr(tic_pkg::IDX_MODE, 8'h80);
    tic_pulse_src_inst.pulse(0, 6);
    idle(12);
    rc(tic_pkg::IDX_CAPEN, 8'h10);
    $display("test modes done");
    wr(tic_pkg::IDX_MODE, 8'h08);
    wr(tic_pkg::IDX_CNTL, 8'h34);
    wr(tic_pkg::IDX_CNTH, 8'h12);
    tic_pulse_src_inst.set_pin(0, 1'b1);
    idle(12);
    rc(tic_pkg::IDX_RES0_LO, 8'h34);
    rc(tic_pkg::IDX_RES0_HI, 8'h12);
    rc(tic_pkg::IDX_CNTL, 8'h00);
    rc(tic_pkg::IDX_CNTH, 8'h00);
    wr(tic_pkg::IDX_MODE, 8'h00);
    wr(tic_pkg::IDX_CNTL, 8'h56);
    tic_pulse_src_inst.set_pin(0, 1'b0);
    idle(12);
    rc(tic_pkg::IDX_RES0_LO, 8'h56);
    rc(tic_pkg::IDX_CNTL, 8'h56);
    $display("test clear_on_capture done");
    wr(tic_pkg::IDX_IEN, 8'h01);
    idle(3);
    chk({31'h0, capture_irq}, 32'h0);
    wr(tic_pkg::IDX_IEN, 8'h02);
    idle(3);
    chk({31'h0, capture_irq}, 32'h0);
    wr(tic_pkg::IDX_IEN, 8'h03);
    idle(3);
    chk({31'h0, capture_irq}, 32'h1);
    wr(tic_pkg::IDX_CAPEN, 8'h10);
    idle(3);
    chk({31'h0, capture_irq}, 32'h0);
    $display("test interrupt done");
    close_out();
  end
endmodule // timer_input_capture_unit_bench
`default_nettype wire
